/* hdl/gtc_defs.svh */
// register offsets, field positions, reset values and timing constants of the gated timer
`ifndef GTC_DEFS_SVH
`define GTC_DEFS_SVH

`define GTC_OFF_CTRL 8'h00
`define GTC_OFF_GATE 8'h04
`define GTC_OFF_CNTL 8'h08
`define GTC_OFF_CNTH 8'h0C
`define GTC_OFF_OSC 8'h10
`define GTC_OFF_IRQ 8'h14

`define GTC_CTRL_CS 7:6
`define GTC_CTRL_PS 5:4
`define GTC_CTRL_OSCEN 3
`define GTC_CTRL_ASYNC 2
`define GTC_CTRL_WIDE 1
`define GTC_CTRL_ON 0

`define GTC_GATE_GCE 7
`define GTC_GATE_POL 6
`define GTC_GATE_VAL 2
`define GTC_GATE_SS 1:0
`define GTC_GATE_WMASK 8'hC3

`define GTC_OSC_RUN 6
`define GTC_OSC_GO 3

`define GTC_IRQ_FLAG 0
`define GTC_IRQ_EN 1

`define GTC_RST_BYTE 8'h00
`define GTC_RST_WORD 32'h0000_0000
`define GTC_CNT_MAX 16'hFFFF
`define GTC_CMP_SPECIAL 4'hB
`define GTC_QUARTER_LAST 2'h3

`endif

/* hdl/gtc_pkg.sv */
// types shared by the gated timer and its bench
package gtc_pkg;

  // clock source codes
  typedef enum logic [1:0] {
    GTC_CS_QUARTER = 2'h0,
    GTC_CS_SYSTEM = 2'h1,
    GTC_CS_EXTERNAL = 2'h2,
    GTC_CS_NONE = 2'h3
  } gtc_clk_sel_t;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } gtc_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } gtc_apb_rsp_t;

  // the four gate sources
  typedef struct packed {
    logic cmp2;
    logic cmp1;
    logic period_match;
    logic gate_pin;
  } gtc_gate_src_t;

  // whole state of the timer
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] gate_cfg;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] high_buffer;
    logic secondary_osc_go;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic [2:0] presc;
    logic [1:0] quarter;
    logic sync_meta;
    logic sync_lvl;
    logic async_lvl;
    logic prev_lvl;
    logic armed;
    logic secondary_clock_running;
    logic osc_enable_out;
    logic irq_out;
    gtc_apb_rsp_t rsp;
  } gtc_state_t;

endpackage

/* hdl/gtc_timer.sv */
// gated sixteen bit timer/counter with apb register access
//
// Notes on behaviour
// - source code 01 system clock, 00 quarter rate, 10 pin or secondary oscillator
// - internal source advances count through the selected prescaler ratio
// - external source counts rising edges, synchronised or asynchronous as chosen
// - counter mode needs a falling edge after enable, count write or disable
// - wide access maps high address to buffer; low read loads buffer
// - wide access: low write moves buffer into live high byte too
// - high buffer write keeps prescaler; low byte write clears prescaler
// - oscillator runs when any oscillator enable or go bit is set
// - read-only status shows secondary oscillator supplying system clock
// - count wraps from all ones to zero and latches overflow flag
// - overflow flag reaches interrupt output only while enable bit set
// - special-event compare trigger clears the count to zero
// - trigger honoured only in timer or synchronous counter mode
// - count write in same cycle as trigger wins over the trigger
// - trigger reset never sets the overflow flag
// - gate enable counts only while gate level matches polarity
// - inactive gate holds the count unchanged
// - two-bit field selects one of four gate sources
// - gate codes: pin, period match, comparator one, comparator two
// - timer runs from timer on bit alone; gate enable bit adds the gate level condition
`timescale 1ns/10ps
`include "gtc_defs.svh"

module gtc_timer #(
  parameter int OTHER_TIMERS = 3
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire gtc_pkg::gtc_apb_req_t I_APB_REQ,
  output gtc_pkg::gtc_apb_rsp_t O_APB_RSP,
  input wire logic I_EXT_COUNT_INPUT,
  input wire logic I_SECONDARY_CRYSTAL_OSCILLATOR_CLK,
  input wire gtc_pkg::gtc_gate_src_t I_GATE_SRC,
  input wire logic I_SPECIAL_TRIG,
  input wire logic [3:0] I_COMPARE_UNIT_MODE,
  input wire logic [OTHER_TIMERS-1:0] I_OTHER_OSC_ENABLE,
  input wire logic I_SECONDARY_CRYSTAL_OSCILLATOR_IS_SYSCLK,
  output logic O_SECONDARY_CRYSTAL_OSCILLATOR_ENABLE,
  output logic O_IRQ,
  output logic [15:0] O_COUNT
);
  import gtc_pkg::*;

  gtc_state_t s_reg;
  gtc_state_t s_next;

  logic setup;
  logic acc;
  logic wr;
  logic wr_ctrl;
  logic wr_gate;
  logic wr_lo;
  logic wr_hi;
  logic wr_osc;
  logic wr_irq;
  logic rd_lo_setup;
  logic cnt_wr;
  logic cnt_touch;
  gtc_clk_sel_t count_clock_select;
  logic wide_access_enable;
  logic timer_on;
  logic async_mode;
  logic ext_mode;
  logic gate_count_enable;
  logic gate_polarity;
  logic [1:0] gate_source_select;
  logic gate_lvl;
  logic gate_ok;
  logic ext_raw;
  logic sel_lvl;
  logic ext_rise;
  logic ext_fall;
  logic tick_src;
  logic run_tick;
  logic [2:0] presc_lim;
  logic inc_en;
  logic trig_ok;
  logic ovf_set;
  logic [15:0] count;
  logic [15:0] count_inc;
  logic [7:0] rd_val;
  logic rd_err;

  // apb phase and write strobes
  assign setup = I_APB_REQ.psel & ~I_APB_REQ.penable;
  assign acc = I_APB_REQ.psel & I_APB_REQ.penable & s_reg.rsp.pready;
  assign wr = acc & I_APB_REQ.pwrite;
  assign wr_ctrl = wr & (I_APB_REQ.paddr == `GTC_OFF_CTRL);
  assign wr_gate = wr & (I_APB_REQ.paddr == `GTC_OFF_GATE);
  assign wr_lo = wr & (I_APB_REQ.paddr == `GTC_OFF_CNTL);
  assign wr_hi = wr & (I_APB_REQ.paddr == `GTC_OFF_CNTH);
  assign wr_osc = wr & (I_APB_REQ.paddr == `GTC_OFF_OSC);
  assign wr_irq = wr & (I_APB_REQ.paddr == `GTC_OFF_IRQ);
  assign rd_lo_setup = setup & ~I_APB_REQ.pwrite & (I_APB_REQ.paddr == `GTC_OFF_CNTL);
  // writes that change the live count, and writes that touch either count byte
  assign cnt_wr = wr_lo | (wr_hi & ~wide_access_enable);
  assign cnt_touch = wr_lo | wr_hi;

  // control fields
  assign count_clock_select = gtc_clk_sel_t'(s_reg.ctrl[`GTC_CTRL_CS]);
  assign wide_access_enable = s_reg.ctrl[`GTC_CTRL_WIDE];
  assign timer_on = s_reg.ctrl[`GTC_CTRL_ON];
  assign async_mode = s_reg.ctrl[`GTC_CTRL_ASYNC];
  assign ext_mode = (count_clock_select == GTC_CS_EXTERNAL);
  assign gate_count_enable = s_reg.gate_cfg[`GTC_GATE_GCE];
  assign gate_polarity = s_reg.gate_cfg[`GTC_GATE_POL];
  assign gate_source_select = s_reg.gate_cfg[`GTC_GATE_SS];

  // gate source mux and polarity
  always_comb begin
    if (gate_source_select == 2'h0) begin
      gate_lvl = I_GATE_SRC.gate_pin;
    end else if (gate_source_select == 2'h1) begin
      gate_lvl = I_GATE_SRC.period_match;
    end else if (gate_source_select == 2'h2) begin
      gate_lvl = I_GATE_SRC.cmp1;
    end else begin
      gate_lvl = I_GATE_SRC.cmp2;
    end
  end
  assign gate_ok = ~gate_count_enable | (gate_lvl == gate_polarity);

  // external level: pin or secondary oscillator, synchronised or taken directly
  assign ext_raw = s_reg.ctrl[`GTC_CTRL_OSCEN] ? I_SECONDARY_CRYSTAL_OSCILLATOR_CLK : I_EXT_COUNT_INPUT;
  assign sel_lvl = async_mode ? s_reg.async_lvl : s_reg.sync_lvl;
  assign ext_rise = sel_lvl & ~s_reg.prev_lvl;
  assign ext_fall = ~sel_lvl & s_reg.prev_lvl;

  // source tick per selected clock
  always_comb begin
    case (count_clock_select)
      GTC_CS_SYSTEM: tick_src = 1'b1;
      GTC_CS_QUARTER: tick_src = (s_reg.quarter == `GTC_QUARTER_LAST);
      GTC_CS_EXTERNAL: tick_src = ext_rise & s_reg.armed;
      default: tick_src = 1'b0;
    endcase
  end

  // prescaler terminal value for ratios 1, 2, 4, 8
  always_comb begin
    case (s_reg.ctrl[`GTC_CTRL_PS])
      2'h0: presc_lim = 3'h0;
      2'h1: presc_lim = 3'h1;
      2'h2: presc_lim = 3'h3;
      default: presc_lim = 3'h7;
    endcase
  end

  assign run_tick = timer_on & tick_src & gate_ok;
  // at or past the terminal value, so a ratio change never skips a full prescaler lap
  assign inc_en = run_tick & (s_reg.presc >= presc_lim);
  assign count = {s_reg.count_high_byte, s_reg.count_low_byte};
  assign count_inc = count + 16'h0001;
  // special event reset, refused in asynchronous counter mode
  assign trig_ok = I_SPECIAL_TRIG & (I_COMPARE_UNIT_MODE == `GTC_CMP_SPECIAL) & ~(ext_mode & async_mode);
  assign ovf_set = inc_en & ~cnt_wr & ~trig_ok & (count == `GTC_CNT_MAX);

  // read data mux
  always_comb begin
    rd_val = `GTC_RST_BYTE;
    rd_err = 1'b0;
    if (I_APB_REQ.paddr == `GTC_OFF_CTRL) begin
      rd_val = s_reg.ctrl;
    end else if (I_APB_REQ.paddr == `GTC_OFF_GATE) begin
      rd_val = s_reg.gate_cfg;
      rd_val[`GTC_GATE_VAL] = gate_lvl;
    end else if (I_APB_REQ.paddr == `GTC_OFF_CNTL) begin
      rd_val = s_reg.count_low_byte;
    end else if (I_APB_REQ.paddr == `GTC_OFF_CNTH) begin
      rd_val = wide_access_enable ? s_reg.high_buffer : s_reg.count_high_byte;
    end else if (I_APB_REQ.paddr == `GTC_OFF_OSC) begin
      rd_val[`GTC_OSC_RUN] = s_reg.secondary_clock_running;
      rd_val[`GTC_OSC_GO] = s_reg.secondary_osc_go;
    end else if (I_APB_REQ.paddr == `GTC_OFF_IRQ) begin
      rd_val[`GTC_IRQ_FLAG] = s_reg.overflow_flag;
      rd_val[`GTC_IRQ_EN] = s_reg.overflow_irq_enable;
    end else begin
      rd_err = 1'b1;
    end
  end

  // next state
  always_comb begin
    s_next = s_reg;
    // apb answer: ready in the access phase, data taken at setup
    s_next.rsp.pready = setup;
    if (setup) begin
      s_next.rsp.prdata = {24'h00_0000, rd_val};
      s_next.rsp.pslverr = rd_err;
    end else begin
      s_next.rsp.prdata = `GTC_RST_WORD;
      s_next.rsp.pslverr = 1'b0;
    end
    // configuration writes
    if (wr_ctrl) begin
      s_next.ctrl = I_APB_REQ.pwdata[7:0];
    end
    if (wr_gate) begin
      s_next.gate_cfg = I_APB_REQ.pwdata[7:0] & `GTC_GATE_WMASK;
    end
    if (wr_osc) begin
      s_next.secondary_osc_go = I_APB_REQ.pwdata[`GTC_OSC_GO];
    end
    if (wr_irq) begin
      s_next.overflow_irq_enable = I_APB_REQ.pwdata[`GTC_IRQ_EN];
    end
    // overflow flag, set beats a write-one clear
    s_next.overflow_flag = ovf_set | (s_reg.overflow_flag & ~(wr_irq & I_APB_REQ.pwdata[`GTC_IRQ_FLAG]));
    // low byte read snapshots the live high byte
    if (rd_lo_setup & wide_access_enable) begin
      s_next.high_buffer = s_reg.count_high_byte;
    end
    if (wr_hi & wide_access_enable) begin
      s_next.high_buffer = I_APB_REQ.pwdata[7:0];
    end
    // external edge sampling
    s_next.sync_meta = ext_raw;
    s_next.sync_lvl = s_reg.sync_meta;
    s_next.async_lvl = ext_raw;
    s_next.prev_lvl = sel_lvl;
    // falling edge arming
    if (cnt_touch | ~timer_on) begin
      s_next.armed = 1'b0;
    end else if (ext_fall) begin
      s_next.armed = 1'b1;
    end
    s_next.quarter = s_reg.quarter + 2'h1;
    // prescaler
    if (wr_lo) begin
      s_next.presc = 3'h0;
    end else if (run_tick) begin
      s_next.presc = inc_en ? 3'h0 : s_reg.presc + 3'h1;
    end
    // count: write, then trigger, then increment
    if (cnt_wr) begin
      if (wr_lo) begin
        s_next.count_low_byte = I_APB_REQ.pwdata[7:0];
        if (wide_access_enable) begin
          s_next.count_high_byte = s_reg.high_buffer;
        end
      end else begin
        s_next.count_high_byte = I_APB_REQ.pwdata[7:0];
      end
    end else if (trig_ok) begin
      s_next.count_low_byte = 8'h00;
      s_next.count_high_byte = 8'h00;
    end else if (inc_en) begin
      s_next.count_low_byte = count_inc[7:0];
      s_next.count_high_byte = count_inc[15:8];
    end
    // oscillator and interrupt outputs
    s_next.osc_enable_out = s_reg.ctrl[`GTC_CTRL_OSCEN] | s_reg.secondary_osc_go | (|I_OTHER_OSC_ENABLE);
    s_next.secondary_clock_running = I_SECONDARY_CRYSTAL_OSCILLATOR_IS_SYSCLK;
    s_next.irq_out = s_reg.overflow_flag & s_reg.overflow_irq_enable;
  end

  // state register
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state
  assign O_APB_RSP = s_reg.rsp;
  assign O_SECONDARY_CRYSTAL_OSCILLATOR_ENABLE = s_reg.osc_enable_out;
  assign O_IRQ = s_reg.irq_out;
  assign O_COUNT = count;

  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  ovf_flag_set_a: assert property (ovf_set |=> s_reg.overflow_flag && count == 16'h0000)
    else $error("wrap did not set flag");
  irq_gate_a: assert property (##1 O_IRQ == $past(s_reg.overflow_flag & s_reg.overflow_irq_enable))
    else $error("irq not gated by enable");
  trig_clear_a: assert property (trig_ok && !cnt_wr |=> count == 16'h0000)
    else $error("trigger did not clear count");
  async_refuse_a: assert property (I_SPECIAL_TRIG && ext_mode && async_mode |-> !trig_ok)
    else $error("trigger honoured in async mode");
  write_wins_a: assert property (wr_lo && trig_ok |=> s_reg.count_low_byte == $past(I_APB_REQ.pwdata[7:0]))
    else $error("trigger beat the write");
  trig_no_flag_a: assert property (trig_ok && !s_reg.overflow_flag |=> !s_reg.overflow_flag)
    else $error("trigger set overflow flag");
  gate_hold_a: assert property (gate_count_enable && gate_lvl != gate_polarity && !cnt_wr && !trig_ok
    |=> $stable(count))
    else $error("count moved with gate inactive");
  off_hold_a: assert property (!timer_on && !cnt_touch && !trig_ok |=> $stable(count) && $stable(s_reg.presc))
    else $error("count moved while off");
  wide_write_a: assert property (wr_lo && wide_access_enable
    |=> s_reg.count_high_byte == $past(s_reg.high_buffer))
    else $error("high byte not loaded from buffer");
  read_buf_a: assert property (rd_lo_setup && wide_access_enable
    |=> s_reg.high_buffer == $past(s_reg.count_high_byte) && O_APB_RSP.pready)
    else $error("low read did not load buffer");
  presc_clear_a: assert property (wr_lo |=> s_reg.presc == 3'h0)
    else $error("prescaler not cleared");
  arm_clear_a: assert property (cnt_touch |=> !s_reg.armed ##1 (!s_reg.armed || $past(ext_fall)))
    else $error("counter armed without falling edge");
  osc_en_a: assert property (##1 O_SECONDARY_CRYSTAL_OSCILLATOR_ENABLE == $past(s_reg.ctrl[`GTC_CTRL_OSCEN] | s_reg.secondary_osc_go
    | (|I_OTHER_OSC_ENABLE)))
    else $error("oscillator enable wrong");
  sys_rate_a: assert property (count_clock_select == GTC_CS_SYSTEM && timer_on && !gate_count_enable
    && presc_lim == 3'h0 && !cnt_wr && !trig_ok |-> inc_en)
    else $error("system clock source did not count");

  wrap_c: cover property (ovf_set ##1 s_reg.overflow_flag);
  trig_c: cover property (trig_ok && count != 16'h0000);
  wide_read_c: cover property (rd_lo_setup && wide_access_enable ##1 acc);
  ext_count_c: cover property (ext_mode && inc_en);

endmodule // gtc_timer

/* verif/gtc_far_end.sv */
// far-side model: external count pin, secondary oscillator output and the four gate sources
`timescale 1ns/10ps
module gtc_far_end (
  input wire logic i_clk,
  output logic o_ext,
  output logic o_osc,
  output gtc_pkg::gtc_gate_src_t o_gate
);
  import gtc_pkg::*;
  // both count clocks idle low and stand still between bursts
  initial begin
    o_ext = 1'b0;
    o_osc = 1'b0;
    o_gate = '0;
  end
  // n pulses on pin or oscillator, two cycles high then two low
  task automatic pulse(input int n, input bit osc);
    repeat (n) begin
      @(posedge i_clk);
      if (osc) o_osc <= 1'b1;
      else o_ext <= 1'b1;
      repeat (2) @(posedge i_clk);
      if (osc) o_osc <= 1'b0;
      else o_ext <= 1'b0;
      @(posedge i_clk);
    end
  endtask
  // selected source at lvl, all others at the opposite level
  task automatic set_gate(input logic lvl, input logic [1:0] ss);
    logic [3:0] g;
    g = {4{~lvl}};
    g[ss] = lvl;
    @(posedge i_clk);
    o_gate <= g;
  endtask
endmodule // gtc_far_end

/* verif/gtc_timer_tb.sv */
// self-checking bench of the gated timer against a small register model
`timescale 1ns/10ps
`include "gtc_defs.svh"
module gtc_timer_tb;
  import gtc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  gtc_apb_req_t req = '0;
  gtc_apb_rsp_t rsp;
  logic trig = 1'b0;
  logic [3:0] mode = 4'h0;
  logic [2:0] others = 3'h0;
  logic on_sys = 1'b0;
  logic ext, osc, osc_en, irq;
  gtc_gate_src_t gate;
  logic [15:0] count;
  logic [31:0] mdl [6];
  logic [31:0] r;
  logic e;
  integer seed = 32'ha621;
  int bad_count = 0;
  int checked = 0;
  // 40 MHz system clock
  always #12.5 clk = ~clk;
  gtc_timer #(.OTHER_TIMERS(3)) i_gtc_timer (.I_CLK(clk), .I_RESET_N(rst_n), .I_APB_REQ(req),
    .O_APB_RSP(rsp), .I_EXT_COUNT_INPUT(ext), .I_SECONDARY_CRYSTAL_OSCILLATOR_CLK(osc), .I_GATE_SRC(gate),
    .I_SPECIAL_TRIG(trig), .I_COMPARE_UNIT_MODE(mode), .I_OTHER_OSC_ENABLE(others),
    .I_SECONDARY_CRYSTAL_OSCILLATOR_IS_SYSCLK(on_sys), .O_SECONDARY_CRYSTAL_OSCILLATOR_ENABLE(osc_en), .O_IRQ(irq), .O_COUNT(count));
  gtc_far_end i_gtc_far_end (.i_clk(clk), .o_ext(ext), .o_osc(osc), .o_gate(gate));
  // verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, request held until pready is sampled high
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      stop_test();
    end
    r = rsp.prdata;
    e = rsp.pslverr;
    @(posedge clk);
    req <= '0;
  endtask
  // register write, mirrored in the model
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
    mdl[a[4:2]] = {24'h00_0000, d};
  endtask
  // count advance over k cycles
  task automatic span(input int k, input logic [15:0] exp);
    logic [15:0] c0;
    @(negedge clk);
    c0 = count;
    repeat (k) @(negedge clk);
    check({16'h0000, count - c0}, {16'h0000, exp});
  endtask
  // one-cycle special event trigger
  task automatic fire();
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // main sequence
  initial begin
    logic [7:0] v;
    logic [15:0] c;
    for (int i = 0; i < 6; i++) mdl[i] = 32'h0000_0000;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, then an unmapped address
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0000_0000);
      check(r & 32'hFFFF_FFFB, mdl[i]);
    end
    apb(1'b0, 8'h18, 32'h0000_0000);
    check({31'h0000_0000, e}, 32'h0000_0001);
    // system clock through every prescale ratio, quarter rate, no source, off
    for (int ps = 0; ps < 4; ps++) begin
      wr(`GTC_OFF_CTRL, 8'h41 | 8'(ps << 4));
      span(16, 16'(16 >> ps));
    end
    wr(`GTC_OFF_CTRL, 8'h01);
    span(16, 16'h0004);
    wr(`GTC_OFF_CTRL, 8'hC1);
    span(8, 16'h0000);
    wr(`GTC_OFF_CTRL, 8'h40);
    span(8, 16'h0000);
    apb(1'b0, `GTC_OFF_CTRL, 32'h0000_0000);
    check(r, mdl[0]);
    // oscillator request from random enable bits, go bit and status flag
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed)) & 8'h08;
      others <= 3'($random(seed));
      wr(`GTC_OFF_CTRL, v);
      repeat (2) @(negedge clk);
      check({31'h0000_0000, osc_en}, {31'h0000_0000, |others | v[3]});
    end
    others <= 3'h0;
    wr(`GTC_OFF_CTRL, 8'h00);
    wr(`GTC_OFF_OSC, 8'h08);
    repeat (2) @(negedge clk);
    check({31'h0000_0000, osc_en}, 32'h0000_0001);
    on_sys <= 1'b1;
    apb(1'b0, `GTC_OFF_OSC, 32'h0000_0000);
    check(r, 32'h0000_0048);
    on_sys <= 1'b0;
    wr(`GTC_OFF_OSC, 8'h00);
    // wide write close to the top, wrap, flag and request, clear
    wr(`GTC_OFF_IRQ, 8'h02);
    wr(`GTC_OFF_CTRL, 8'h43);
    wr(`GTC_OFF_CNTH, 8'hFF);
    wr(`GTC_OFF_CNTL, 8'hFE);
    repeat (4) @(posedge clk);
    apb(1'b0, `GTC_OFF_IRQ, 32'h0000_0000);
    check(r, 32'h0000_0003);
    check({31'h0000_0000, irq}, 32'h0000_0001);
    wr(`GTC_OFF_IRQ, 8'h01);
    apb(1'b0, `GTC_OFF_IRQ, 32'h0000_0000);
    check(r, 32'h0000_0000);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    // wide access with the timer stopped
    wr(`GTC_OFF_CTRL, 8'h42);
    wr(`GTC_OFF_CNTH, 8'h12);
    wr(`GTC_OFF_CNTL, 8'h34);
    wr(`GTC_OFF_CNTH, 8'h77);
    check({16'h0000, count}, 32'h0000_1234);
    apb(1'b0, `GTC_OFF_CNTL, 32'h0000_0000);
    check(r, 32'h0000_0034);
    apb(1'b0, `GTC_OFF_CNTH, 32'h0000_0000);
    check(r, 32'h0000_0012);
    // special event trigger clears without a flag; compare mode 0 ignored
    mode <= `GTC_CMP_SPECIAL;
    fire();
    check({16'h0000, count}, 32'h0000_0000);
    apb(1'b0, `GTC_OFF_IRQ, 32'h0000_0000);
    check(r, 32'h0000_0000);
    mode <= 4'h0;
    wr(`GTC_OFF_CNTL, 8'h34);
    fire();
    check({16'h0000, count}, 32'h0000_1234);
    // gate sources with alternating polarity
    wr(`GTC_OFF_CTRL, 8'h41);
    for (int ss = 0; ss < 4; ss++) begin
      wr(`GTC_OFF_GATE, 8'h80 | 8'((ss & 1) << 6) | 8'(ss));
      i_gtc_far_end.set_gate(~ss[0], 2'(ss));
      repeat (4) @(posedge clk);
      span(8, 16'h0000);
      i_gtc_far_end.set_gate(ss[0], 2'(ss));
      repeat (4) @(posedge clk);
      span(8, 16'h0008);
    end
    wr(`GTC_OFF_GATE, 8'h00);
    // pin synchronised, pin asynchronous, oscillator; first rise after enable ignored
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h81 : (i == 1) ? 8'h85 : 8'h89;
      wr(`GTC_OFF_CTRL, 8'h00);
      wr(`GTC_OFF_CTRL, v);
      c = count;
      i_gtc_far_end.pulse(3, i == 2);
      repeat (4) @(posedge clk);
      check({16'h0000, count - c}, 32'h0000_0002);
    end
    stop_test();
  end
endmodule // gtc_timer_tb
